// ===== hdl/nvda_cfg_if.sv
// link between the access controller and the configuration space store
`timescale 1ns/1ns
interface nvda_cfg_if;
   import nvda_pkg::*;
   logic [CFG_AW-1:0] addr;
   logic              wr;
   logic [WORD_W-1:0] wdata;
   logic [WORD_W-1:0] rdata;
   logic              hit;
   logic              writable;
   modport ctl   (output addr, output wr, output wdata,
                  input rdata, input hit, input writable);
   modport store (input addr, input wr, input wdata,
                  output rdata, output hit, output writable);
endinterface

// ===== hdl/nvda_cfg_store.sv
// configuration space store: user ids, device id and configuration words
`timescale 1ns/1ns
module nvda_cfg_store
   import nvda_pkg::*;
#(
   // identity and configuration values are arbitrary
   parameter logic [WORD_W-1:0] DEV_ID_VAL    = 14'h0a5a,
   parameter logic [WORD_W-1:0] CFG_WORD1_VAL = 14'h3fff,
   parameter logic [WORD_W-1:0] CFG_WORD2_VAL = 14'h3fff
) (
   input wire logic mclk,
   input wire logic nrst,
   nvda_cfg_if.store cif
);
   logic [WORD_W-1:0] uid      [CFG_UID_N];
   logic [WORD_W-1:0] next_uid [CFG_UID_N];
   logic              uid_hit;
   logic [CFG_UID_IW-1:0] uid_idx;

   assign uid_hit = (cif.addr >= CFG_UID_FIRST) && (cif.addr <= CFG_UID_LAST);
   assign uid_idx = cif.addr[CFG_UID_IW-1:0];

   genvar gi;
   generate
      for (gi = 0; gi < CFG_UID_N; gi++) begin : g_uid
         always_comb begin
            next_uid[gi] = uid[gi];
            if (cif.wr && uid_hit && (uid_idx == CFG_UID_IW'(gi))) begin
               next_uid[gi] = cif.wdata;
            end
         end
         always_ff @(posedge mclk or negedge nrst) begin
            if (!nrst) begin
               uid[gi] <= DATA_RST;
            end else begin
               uid[gi] <= next_uid[gi];
            end
         end
      end
   endgenerate

   always_comb begin
      cif.rdata    = DATA_CLEAR;
      cif.hit      = 1'b1;
      cif.writable = 1'b0;
      if (uid_hit) begin
         cif.rdata    = uid[uid_idx];
         cif.writable = 1'b1;
      end else if (cif.addr == CFG_DEV_ID) begin
         cif.rdata = DEV_ID_VAL;
      end else if (cif.addr == CFG_WORD1) begin
         cif.rdata = CFG_WORD1_VAL;
      end else if (cif.addr == CFG_WORD2) begin
         cif.rdata = CFG_WORD2_VAL;
      end else begin
         cif.hit = 1'b0;
      end
   end
endmodule

// ===== hdl/nvda_pkg.sv
// shared constants and types for the nonvolatile data/address access block
package nvda_pkg;
   localparam int unsigned REG_AW      = 3;
   localparam int unsigned BYTE_W      = 8;
   localparam int unsigned WORD_W      = 14;
   localparam int unsigned HIGH_W      = 6;
   localparam int unsigned ADDR_W      = 15;
   localparam int unsigned ADDR_HIGH_W = 7;
   localparam int unsigned CFG_AW      = 16;
   localparam int unsigned CFG_UID_N   = 4;
   localparam int unsigned CFG_UID_IW  = 2;

   localparam logic [REG_AW-1:0] OFS_DATA_LOW  = 3'h0;
   localparam logic [REG_AW-1:0] OFS_DATA_HIGH = 3'h1;
   localparam logic [REG_AW-1:0] OFS_ADDR_LOW  = 3'h2;
   localparam logic [REG_AW-1:0] OFS_ADDR_HIGH = 3'h3;
   localparam logic [REG_AW-1:0] OFS_CONTROL   = 3'h4;

   localparam int unsigned CTL_READ       = 0;
   localparam int unsigned CTL_WRITE      = 1;
   localparam int unsigned CTL_WREN       = 2;
   localparam int unsigned CTL_WRERR      = 3;
   localparam int unsigned CTL_FREE       = 4;
   localparam int unsigned CTL_LATCH_ONLY = 5;
   localparam int unsigned CTL_CFG_SEL    = 6;
   localparam int unsigned CTL_PROG_SEL   = 7;

   localparam logic [BYTE_W-1:0]      CTRL_RST      = 8'h00;
   localparam logic [BYTE_W-1:0]      ADDR_LOW_RST  = 8'h00;
   localparam logic [ADDR_HIGH_W-1:0] ADDR_HIGH_RST = 7'h00;
   localparam logic [WORD_W-1:0]      DATA_RST      = 14'h0000;
   localparam logic [WORD_W-1:0]      DATA_CLEAR    = 14'h0000;
   localparam logic [1:0]             DATA_HIGH_PAD = 2'h0;
   localparam logic                   ADDR_HIGH_PAD = 1'b1;
   localparam logic [BYTE_W-1:0]      READ_ZERO     = 8'h00;

   localparam logic [CFG_AW-1:0] CFG_UID_FIRST = 16'h8000;
   localparam logic [CFG_AW-1:0] CFG_UID_LAST  = 16'h8003;
   localparam logic [CFG_AW-1:0] CFG_DEV_ID    = 16'h8006;
   localparam logic [CFG_AW-1:0] CFG_WORD1     = 16'h8007;
   localparam logic [CFG_AW-1:0] CFG_WORD2     = 16'h8008;
   localparam logic              CFG_SPACE_BIT = 1'b1;

   typedef enum logic [2:0] {
      st_idle,
      st_rd_issue,
      st_rd_wait,
      st_wr_issue,
      st_wr_wait
   } nvda_state_e;
endpackage

// ===== hdl/nvda_top.sv
// data/address holding registers and access sequencer of the nonvolatile memory
//
// The register addresses and strobed register access were decided locally.
`timescale 1ns/1ns
module nvda_top
   import nvda_pkg::*;
#(
   // identity and configuration values are arbitrary
   parameter logic [WORD_W-1:0] DEV_ID_VAL    = 14'h0a5a,
   parameter logic [WORD_W-1:0] CFG_WORD1_VAL = 14'h3fff,
   parameter logic [WORD_W-1:0] CFG_WORD2_VAL = 14'h3fff
) (
   input  wire logic              mclk,
   input  wire logic              nrst,
   input  wire logic [REG_AW-1:0] reg_addr,
   input  wire logic [BYTE_W-1:0] reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output      logic [BYTE_W-1:0] reg_rdata,
   output      logic [ADDR_W-1:0] mem_addr,
   output      logic              mem_prog,
   output      logic [WORD_W-1:0] mem_wdata,
   output      logic              mem_rd,
   output      logic              mem_wr,
   output      logic              mem_erase,
   output      logic              mem_latch_only,
   input  wire logic [WORD_W-1:0] mem_rdata,
   input  wire logic              mem_done
);
   nvda_cfg_if cif ();

   nvda_cfg_store #(
      .DEV_ID_VAL    (DEV_ID_VAL),
      .CFG_WORD1_VAL (CFG_WORD1_VAL),
      .CFG_WORD2_VAL (CFG_WORD2_VAL)
   ) u_cfg (
      .mclk (mclk),
      .nrst (nrst),
      .cif  (cif)
   );

   // register write decode, used for every software-written register
   function automatic logic reg_hit(input logic             strobe,
                                    input logic [REG_AW-1:0] a,
                                    input logic [REG_AW-1:0] ofs);
      reg_hit = strobe && (a == ofs);
   endfunction

   logic [WORD_W-1:0]      data_word;
   logic [WORD_W-1:0]      next_data_word;
   logic [BYTE_W-1:0]      addr_low;
   logic [BYTE_W-1:0]      next_addr_low;
   logic [ADDR_HIGH_W-1:0] addr_high;
   logic [ADDR_HIGH_W-1:0] next_addr_high;
   logic [BYTE_W-1:0]      ctrl;
   logic [BYTE_W-1:0]      next_ctrl;
   logic [BYTE_W-1:0]      next_reg_rdata;
   nvda_state_e            state;
   nvda_state_e            next_state;
   logic                   next_mem_rd;
   logic                   next_mem_wr;
   logic                   next_mem_erase;
   logic                   next_mem_latch_only;
   logic                   next_mem_prog;
   logic [ADDR_W-1:0]      next_mem_addr;
   logic [WORD_W-1:0]      next_mem_wdata;

   logic              wr_data_low;
   logic              wr_data_high;
   logic              wr_addr_low;
   logic              wr_addr_high;
   logic              wr_ctrl;
   logic [ADDR_W-1:0] full_addr;
   logic              cfg_sel;
   logic              capture;
   logic [WORD_W-1:0] capture_word;
   logic              rd_done;
   logic              wr_done;
   logic              wr_start;

   assign wr_data_low  = reg_hit(reg_wr, reg_addr, OFS_DATA_LOW);
   assign wr_data_high = reg_hit(reg_wr, reg_addr, OFS_DATA_HIGH);
   assign wr_addr_low  = reg_hit(reg_wr, reg_addr, OFS_ADDR_LOW);
   assign wr_addr_high = reg_hit(reg_wr, reg_addr, OFS_ADDR_HIGH);
   assign wr_ctrl      = reg_hit(reg_wr, reg_addr, OFS_CONTROL);

   assign full_addr = {addr_high, addr_low};
   assign cfg_sel   = ctrl[CTL_CFG_SEL];

   // configuration space is the region with the top address bit set
   assign cif.addr  = {CFG_SPACE_BIT, full_addr};
   assign cif.wdata = data_word;
   assign cif.wr    = (state == st_wr_issue) && cfg_sel && cif.writable;

   // access sequencer
   always_comb begin
      next_state          = state;
      next_mem_rd         = 1'b0;
      next_mem_wr         = 1'b0;
      next_mem_erase      = mem_erase;
      next_mem_latch_only = mem_latch_only;
      next_mem_prog       = mem_prog;
      next_mem_addr       = mem_addr;
      next_mem_wdata      = mem_wdata;
      capture             = 1'b0;
      capture_word        = DATA_CLEAR;
      rd_done             = 1'b0;
      wr_done             = 1'b0;
      wr_start            = ctrl[CTL_WRITE] && ctrl[CTL_WREN];
      case (state)
         st_idle: begin
            if (ctrl[CTL_READ]) begin
               next_state    = st_rd_issue;
               next_mem_rd   = !cfg_sel;
               next_mem_prog = ctrl[CTL_PROG_SEL];
               next_mem_addr = full_addr;
            end else if (wr_start) begin
               next_state          = st_wr_issue;
               next_mem_wr         = !cfg_sel;
               next_mem_prog       = ctrl[CTL_PROG_SEL];
               next_mem_erase      = ctrl[CTL_FREE];
               next_mem_latch_only = ctrl[CTL_LATCH_ONLY];
               next_mem_addr       = full_addr;
               next_mem_wdata      = data_word;
            end else if (ctrl[CTL_WRITE]) begin
               // write strobe without write enable is dropped
               wr_done = 1'b1;
            end
         end
         st_rd_issue: begin
            next_state = st_rd_wait;
         end
         st_rd_wait: begin
            capture = 1'b1;
            rd_done = 1'b1;
            if (!cfg_sel) begin
               capture_word = mem_rdata;
            end else if (cif.hit) begin
               capture_word = cif.rdata;
            end else begin
               capture_word = DATA_CLEAR;
            end
            next_state = st_idle;
         end
         st_wr_issue: begin
            if (cfg_sel) begin
               wr_done    = 1'b1;
               next_state = st_idle;
            end else begin
               next_state = st_wr_wait;
            end
         end
         st_wr_wait: begin
            if (mem_done) begin
               wr_done    = 1'b1;
               next_state = st_idle;
            end
         end
         default: begin
            next_state = st_idle;
         end
      endcase
   end

   // sequencer state and array side outputs
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         state          <= st_idle;
         mem_rd         <= 1'b0;
         mem_wr         <= 1'b0;
         mem_erase      <= 1'b0;
         mem_latch_only <= 1'b0;
         mem_prog       <= 1'b0;
         mem_addr       <= {ADDR_W{1'b0}};
         mem_wdata      <= DATA_RST;
      end else begin
         state          <= next_state;
         mem_rd         <= next_mem_rd;
         mem_wr         <= next_mem_wr;
         mem_erase      <= next_mem_erase;
         mem_latch_only <= next_mem_latch_only;
         mem_prog       <= next_mem_prog;
         mem_addr       <= next_mem_addr;
         mem_wdata      <= next_mem_wdata;
      end
   end

   // software registers
   always_comb begin
      next_data_word = data_word;
      if (wr_data_low) begin
         next_data_word[BYTE_W-1:0] = reg_wdata;
      end
      if (wr_data_high) begin
         next_data_word[WORD_W-1:BYTE_W] = reg_wdata[HIGH_W-1:0];
      end
      // a completed fetch wins over a software write in the same cycle
      if (capture) begin
         next_data_word = capture_word;
      end
   end

   // data word pair
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         data_word <= DATA_RST;
      end else begin
         data_word <= next_data_word;
      end
   end

   always_comb begin
      next_addr_low  = addr_low;
      next_addr_high = addr_high;
      if (wr_addr_low) begin
         next_addr_low = reg_wdata;
      end
      if (wr_addr_high) begin
         next_addr_high = reg_wdata[ADDR_HIGH_W-1:0];
      end
   end

   // address pair
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         addr_low  <= ADDR_LOW_RST;
         addr_high <= ADDR_HIGH_RST;
      end else begin
         addr_low  <= next_addr_low;
         addr_high <= next_addr_high;
      end
   end

   always_comb begin
      next_ctrl = ctrl;
      if (wr_ctrl) begin
         next_ctrl[CTL_PROG_SEL]   = reg_wdata[CTL_PROG_SEL];
         next_ctrl[CTL_CFG_SEL]    = reg_wdata[CTL_CFG_SEL];
         next_ctrl[CTL_LATCH_ONLY] = reg_wdata[CTL_LATCH_ONLY];
         next_ctrl[CTL_FREE]       = reg_wdata[CTL_FREE];
         next_ctrl[CTL_WRERR]      = reg_wdata[CTL_WRERR];
         next_ctrl[CTL_WREN]       = reg_wdata[CTL_WREN];
      end
      // strobes clear when done; a fresh software set wins over that clear
      if (rd_done) begin
         next_ctrl[CTL_READ] = 1'b0;
      end
      if (wr_done) begin
         next_ctrl[CTL_WRITE] = 1'b0;
         next_ctrl[CTL_FREE]  = 1'b0;
      end
      if (wr_ctrl && reg_wdata[CTL_READ]) begin
         next_ctrl[CTL_READ] = 1'b1;
      end
      if (wr_ctrl && reg_wdata[CTL_WRITE]) begin
         next_ctrl[CTL_WRITE] = 1'b1;
      end
   end

   // control register
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         ctrl <= CTRL_RST;
      end else begin
         ctrl <= next_ctrl;
      end
   end

   // read-back mux
   always_comb begin
      next_reg_rdata = READ_ZERO;
      if (reg_rd) begin
         case (reg_addr)
            OFS_DATA_LOW:  next_reg_rdata = data_word[BYTE_W-1:0];
            OFS_DATA_HIGH: next_reg_rdata = {DATA_HIGH_PAD, data_word[WORD_W-1:BYTE_W]};
            OFS_ADDR_LOW:  next_reg_rdata = addr_low;
            OFS_ADDR_HIGH: next_reg_rdata = {ADDR_HIGH_PAD, addr_high};
            OFS_CONTROL:   next_reg_rdata = ctrl;
            default:       next_reg_rdata = READ_ZERO;
         endcase
      end
   end

   // read data stands one cycle after the strobe
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         reg_rdata <= READ_ZERO;
      end else begin
         reg_rdata <= next_reg_rdata;
      end
   end
endmodule

// ===== verif/nvda_top_asserts.sv
// port-level assertions for the nonvolatile data/address access block
`timescale 1ns/1ns
module nvda_asserts
   import nvda_pkg::*;
(
   input wire logic              mclk,
   input wire logic              nrst,
   input wire logic [REG_AW-1:0] reg_addr,
   input wire logic [BYTE_W-1:0] reg_wdata,
   input wire logic              reg_wr,
   input wire logic              reg_rd,
   input wire logic [BYTE_W-1:0] reg_rdata,
   input wire logic [ADDR_W-1:0] mem_addr,
   input wire logic              mem_prog,
   input wire logic [WORD_W-1:0] mem_wdata,
   input wire logic              mem_rd,
   input wire logic              mem_wr,
   input wire logic              mem_erase,
   input wire logic              mem_latch_only,
   input wire logic [WORD_W-1:0] mem_rdata,
   input wire logic              mem_done
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);
   wire ctl_wr = reg_wr && reg_addr == OFS_CONTROL;
   property p_rst_quiet;
      $rose(nrst) |-> reg_rdata == READ_ZERO && !mem_rd && !mem_wr;
   endproperty
   a_rst_quiet: assert property (p_rst_quiet) else $error("outputs busy after reset");
   property p_high_pad;
      reg_rd && reg_addr == OFS_DATA_HIGH |=> reg_rdata[7:6] == DATA_HIGH_PAD;
   endproperty
   a_high_pad: assert property (p_high_pad) else $error("data high pad bits set");
   property p_addr_pad;
      reg_rd && reg_addr == OFS_ADDR_HIGH |=> reg_rdata[7] == ADDR_HIGH_PAD;
   endproperty
   a_addr_pad: assert property (p_addr_pad) else $error("address high bit 7 not one");
   property p_addr_low;
      reg_wr && reg_addr == OFS_ADDR_LOW ##1 reg_rd && reg_addr == OFS_ADDR_LOW
         |=> reg_rdata == $past(reg_wdata, 2);
   endproperty
   a_addr_low: assert property (p_addr_low) else $error("address low readback wrong");
   property p_fetch;
      ctl_wr && reg_wdata[0] && !reg_wdata[6] |-> ##2 mem_rd && mem_prog == $past(reg_wdata[7], 2);
   endproperty
   a_fetch: assert property (p_fetch) else $error("array read not started");
   property p_cfg_no_array;
      ctl_wr && reg_wdata[0] && reg_wdata[6] |=> !mem_rd [*4];
   endproperty
   a_cfg_no_array: assert property (p_cfg_no_array) else $error("array read in config space");
   property p_pulses;
      (mem_rd || mem_wr) |=> !mem_rd && !mem_wr;
   endproperty
   a_pulses: assert property (p_pulses) else $error("array strobe longer than one cycle");
   property p_low_word;
      mem_rd ##2 (reg_rd && reg_addr == OFS_DATA_LOW) |=> reg_rdata == $past(mem_rdata[7:0], 2);
   endproperty
   a_low_word: assert property (p_low_word) else $error("data low not array word");
   property p_high_word;
      mem_rd ##3 (reg_rd && reg_addr == OFS_DATA_HIGH)
         |=> reg_rdata == {DATA_HIGH_PAD, $past(mem_rdata[13:8], 3)};
   endproperty
   a_high_word: assert property (p_high_word) else $error("data high not array word");
   c_read: cover property (mem_rd);
   c_write: cover property (mem_wr ##[1:8] mem_done);
   c_unmapped: cover property (reg_rd && reg_addr > OFS_CONTROL);
endmodule
bind nvda_top nvda_asserts u_chk (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .mem_addr(mem_addr), .mem_prog(mem_prog), .mem_wdata(mem_wdata), .mem_rd(mem_rd),
   .mem_wr(mem_wr), .mem_erase(mem_erase), .mem_latch_only(mem_latch_only),
   .mem_rdata(mem_rdata), .mem_done(mem_done));

// ===== verif/nvda_top_bench.sv
// self-checking bench for the nonvolatile data/address access block
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin error_cnt++; \
   $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module nvda_top_bench;
   import nvda_pkg::*;
   // identity and configuration values are arbitrary
   localparam logic [WORD_W-1:0] DEV = 14'h2c3d;
   localparam logic [WORD_W-1:0] CW1 = 14'h0f0f;
   localparam logic [WORD_W-1:0] CW2 = 14'h3355;
   logic              mclk, nrst, reg_wr, reg_rd, rd_pend;
   logic              mem_prog, mem_rd, mem_wr, mem_erase, mem_latch_only, mem_done;
   logic              exp_prog, exp_er, exp_lo;
   logic [REG_AW-1:0] reg_addr;
   logic [BYTE_W-1:0] reg_wdata, reg_rdata, exp_v, c;
   logic [ADDR_W-1:0] mem_addr, exp_addr;
   logic [WORD_W-1:0] mem_wdata, mem_rdata, arr_word, w;
   logic [WORD_W-1:0] uid [4];
   logic [WORD_W-1:0] ro [3];
   logic [BYTE_W-1:0] exp_q [$];
   logic [2:0]        dcnt;
   int                error_cnt, checks_done, cyc, rd_cnt, wr_cnt, i, seed;
   nvda_top #(.DEV_ID_VAL(DEV), .CFG_WORD1_VAL(CW1), .CFG_WORD2_VAL(CW2)) uut (
      .mclk(mclk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_addr(mem_addr),
      .mem_prog(mem_prog), .mem_wdata(mem_wdata), .mem_rd(mem_rd), .mem_wr(mem_wr),
      .mem_erase(mem_erase), .mem_latch_only(mem_latch_only), .mem_rdata(mem_rdata),
      .mem_done(mem_done));
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   task automatic results();
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic wr(input logic [REG_AW-1:0] a, input logic [BYTE_W-1:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_rd <= 1'b0;
      reg_addr <= a;
      reg_wdata <= d;
   endtask
   task automatic rd(input logic [REG_AW-1:0] a, input logic [BYTE_W-1:0] ex);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_wr <= 1'b0;
      reg_addr <= a;
      exp_q.push_back(ex);
   endtask
   task automatic idle(input int n);
      @(posedge mclk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      repeat (n - 1) @(posedge mclk);
   endtask
   task automatic setw(input logic [WORD_W-1:0] d);
      wr(OFS_DATA_LOW, d[7:0]);
      wr(OFS_DATA_HIGH, {2'h0, d[13:8]});
   endtask
   task automatic go(input logic [BYTE_W-1:0] ctl, input int n);
      wr(OFS_CONTROL, ctl);
      idle(n);
   endtask
   task automatic chkw(input logic [WORD_W-1:0] d);
      rd(OFS_DATA_LOW, d[7:0]);
      rd(OFS_DATA_HIGH, {2'h0, d[13:8]});
   endtask
   // register read results, oldest expectation first
   always @(posedge mclk) begin
      rd_pend <= reg_rd;
      if (rd_pend === 1'b1) begin
         exp_v = exp_q.pop_front();
         `CHK("reg_rdata", exp_v, reg_rdata)
      end
   end
   // array side: registered read data, write completion after three cycles
   always @(posedge mclk) begin
      mem_rdata <= (mem_rd === 1'b1) ? arr_word : ~mem_rdata;
      mem_done <= (dcnt == 3'h1);
      dcnt <= (mem_wr === 1'b1) ? 3'h3 : ((dcnt != 3'h0) ? dcnt - 3'h1 : 3'h0);
      if (mem_rd === 1'b1) begin
         rd_cnt++;
         `CHK("mem_addr", exp_addr, mem_addr)
         `CHK("mem_prog", exp_prog, mem_prog)
      end
      if (mem_wr === 1'b1) begin
         wr_cnt++;
         `CHK("mem_wdata", w, mem_wdata)
         `CHK("mem_erase", exp_er, mem_erase)
         `CHK("mem_latch_only", exp_lo, mem_latch_only)
         `CHK("mem_addr", exp_addr, mem_addr)
      end
      cyc++;
      if (cyc == 3000) begin
         error_cnt++;
         results();
      end
   end
   initial begin
      seed = 32'hd0af18ff;
      {nrst, reg_wr, reg_rd, rd_pend, mem_done, dcnt, reg_addr, reg_wdata} = '0;
      {mem_rdata, arr_word, w, exp_addr, exp_prog, exp_er, exp_lo} = '0;
      ro = '{DEV, CW1, CW2};
      repeat (8) @(posedge mclk);
      nrst <= 1'b1;
      rd(OFS_ADDR_LOW, ADDR_LOW_RST);
      rd(OFS_ADDR_HIGH, 8'h80);
      rd(OFS_CONTROL, CTRL_RST);
      rd(3'h5, READ_ZERO);
      wr(OFS_DATA_HIGH, 8'hff);
      rd(OFS_DATA_HIGH, 8'h3f);
      wr(OFS_ADDR_HIGH, 8'hff);
      rd(OFS_ADDR_HIGH, 8'hff);
      wr(OFS_ADDR_LOW, 8'h5a);
      rd(OFS_ADDR_LOW, 8'h5a);
      // word fetch from flash, then from EEPROM
      for (i = 0; i < 2; i++) begin
         arr_word = $random(seed);
         exp_addr = $random(seed);
         exp_prog = (i == 0);
         wr(OFS_ADDR_LOW, exp_addr[7:0]);
         wr(OFS_ADDR_HIGH, {1'b0, exp_addr[14:8]});
         go({exp_prog, 7'h01}, 3);
         chkw(arr_word);
         rd(OFS_CONTROL, {exp_prog, 7'h00});
      end
      // erase, latch load, program, then write without enable
      exp_prog = 1'b1;
      w = $random(seed);
      setw(w);
      foreach (ro[k]) begin
         c = (k == 0) ? 8'h96 : ((k == 1) ? 8'ha6 : 8'h86);
         exp_er = c[CTL_FREE];
         exp_lo = c[CTL_LATCH_ONLY];
         go(c, 12);
         rd(OFS_CONTROL, c & 8'hed);
      end
      go(8'h82, 4);
      rd(OFS_CONTROL, 8'h80);
      arr_word = w;
      go(8'h81, 3);
      chkw(w);
      // configuration space: user ids, read-only words, unmapped
      wr(OFS_ADDR_HIGH, 8'h00);
      for (i = 0; i < CFG_UID_N; i++) begin
         uid[i] = $random(seed);
         setw(uid[i]);
         wr(OFS_ADDR_LOW, 8'(i));
         go(8'h46, 4);
      end
      for (i = 0; i < CFG_UID_N; i++) begin
         wr(OFS_ADDR_LOW, 8'(i));
         go(8'h41, 3);
         chkw(uid[i]);
      end
      for (i = 0; i < 3; i++) begin
         wr(OFS_ADDR_LOW, 8'(6 + i));
         setw(~ro[i]);
         go(8'h46, 4);
         go(8'h41, 3);
         chkw(ro[i]);
      end
      setw(14'h3fff);
      wr(OFS_ADDR_LOW, 8'h04);
      go(8'h41, 3);
      chkw(DATA_CLEAR);
      idle(4);
      `CHK("array reads", 3, rd_cnt)
      `CHK("array writes", 3, wr_cnt)
      results();
   end
endmodule
